// *** efs_pkg.sv ***
// shared constants and types of the encoder fieldbus slave data block
package efs_pkg;
    // configuration byte layout and codes
    localparam int         CFG_CONS_BIT   = 7;
    localparam int         CFG_WORD_BIT   = 6;
    localparam int         CFG_DIR_MSB    = 5;
    localparam int         CFG_DIR_LSB    = 4;
    localparam logic [1:0] CFG_DIR_IN     = 2'h1;
    localparam logic [1:0] CFG_DIR_OUT    = 2'h2;
    localparam logic [7:0] CFG_IN4        = 8'hd1;
    localparam logic [7:0] CFG_IN8        = 8'hd3;
    localparam logic [7:0] CFG_OUT4       = 8'he1;

    // operating parameter byte
    localparam int         OPER_DIR_BIT   = 0;
    localparam int         OPER_EXT_BIT   = 1;
    localparam int         OPER_SCALE_BIT = 3;
    localparam int         OPER_PV_BIT    = 7;
    localparam logic [7:0] OPER_MASK      = 8'h8b;
    localparam logic [7:0] OPER_RST       = 8'h0a;

    // velocity unit codes
    localparam logic [7:0] VU_SPS         = 8'h00;
    localparam logic [7:0] VU_RPM         = 8'h01;
    localparam logic [7:0] VU_RST         = VU_SPS;

    // preset word
    localparam int         PRESET_BIT     = 31;
    localparam int         PRESET_HOLD    = 3;

    // diagnostic reply
    localparam int         DIAG_LEN       = 16;
    localparam logic [7:0] DIAG_HDR       = 8'h0a;
    localparam logic [7:0] DIAG_ALARMS    = 8'h00;
    localparam logic [3:0] DG_MASTER      = 4'h3;
    localparam logic [3:0] DG_ID_MSB      = 4'h4;
    localparam logic [3:0] DG_ID_LSB      = 4'h5;
    localparam logic [3:0] DG_HEADER      = 4'h6;
    localparam logic [3:0] DG_ALARMS      = 4'h7;
    localparam logic [3:0] DG_OPSTAT      = 4'h8;
    localparam logic [3:0] DG_TYPE        = 4'h9;
    localparam logic [3:0] DG_ST_RES      = 4'ha;
    localparam logic [3:0] DG_REVS        = 4'he;

    // register map
    localparam int         ADDR_W         = 8;
    localparam logic [7:0] REG_OPER       = 8'h00;
    localparam logic [7:0] REG_VUNIT      = 8'h04;
    localparam logic [7:0] REG_TOTRES     = 8'h08;
    localparam logic [7:0] REG_STATUS     = 8'h0c;
    localparam logic [7:0] REG_POS        = 8'h10;
    localparam logic [7:0] REG_OFFSET     = 8'h14;

    typedef enum logic [2:0] {
        ST_WAIT_CFG = 3'b001,
        ST_XCHG     = 3'b010,
        ST_FAULT    = 3'b100
    } efs_state_e;
endpackage

// *** efs_preset_qual.sv ***
// qualifies a preset word held by the master over several exchanges
module efs_preset_qual #(
    parameter int HOLD = efs_pkg::PRESET_HOLD
) (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        enable,
    input  wire logic        strobe,
    input  wire logic [31:0] word,
    output logic             hit
);
    logic [3:0]  cnt;
    logic [31:0] last;
    logic        flag;
    logic        same;

    generate
        if (HOLD < 1 || HOLD > 14)
            $error("efs_preset_qual: HOLD out of range");
    endgenerate

    assign flag = word[efs_pkg::PRESET_BIT];
    assign same = (word == last) || (cnt == 4'h0);
    assign hit  = enable && strobe && flag && same && (cnt == 4'(HOLD - 1));

    // saturates at HOLD so a held word is applied once, not every few cycles
    always_ff @(posedge mclk)
    begin
        if (reset || !enable)
            cnt <= 4'h0;
        else if (strobe)
        begin
            if (!flag)
                cnt <= 4'h0;
            else if (!same)
                cnt <= 4'h1;
            else if (cnt != 4'(HOLD))
                cnt <= cnt + 4'h1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            last <= 32'h0;
        else if (strobe)
            last <= word;
    end
endmodule

// *** efs_diag_mem.sv ***
// sixteen-byte diagnostic reply, read out through a register
module efs_diag_mem #(
    parameter logic [15:0] IDENT    = 16'h0bee,  // arbitrary value
    parameter logic [7:0]  ENC_TYPE = 8'h01,
    parameter int          ST_BITS  = 16,
    parameter int          MT_BITS  = 14
) (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        rd,
    input  wire logic [3:0]  addr,
    input  wire logic [23:0] station,
    input  wire logic [7:0]  master_addr,
    input  wire logic [7:0]  op_status,
    output logic [7:0]       rdata,
    output logic             rvalid
);
    localparam logic [31:0] ST_RES = 32'h1 << ST_BITS;
    localparam logic [15:0] REVS   = 16'h1 << MT_BITS;

    generate
        if (ST_BITS < 1 || ST_BITS > 31 || MT_BITS < 0 || MT_BITS > 15)
            $error("efs_diag_mem: resolution parameters out of range");
    endgenerate

    logic [7:0] next_rdata;
    logic [1:0] lane;

    assign lane = addr[1:0] - efs_pkg::DG_ST_RES[1:0];

    always_comb
    begin
        next_rdata = 8'h00;
        if (addr < efs_pkg::DG_MASTER)
            next_rdata = station[8'(23 - 8 * addr) -: 8];
        else if (addr == efs_pkg::DG_MASTER)
            next_rdata = master_addr;
        else if (addr == efs_pkg::DG_ID_MSB)
            next_rdata = IDENT[15:8];
        else if (addr == efs_pkg::DG_ID_LSB)
            next_rdata = IDENT[7:0];
        else if (addr == efs_pkg::DG_HEADER)
            next_rdata = efs_pkg::DIAG_HDR;
        else if (addr == efs_pkg::DG_ALARMS)
            next_rdata = efs_pkg::DIAG_ALARMS;
        else if (addr == efs_pkg::DG_OPSTAT)
            next_rdata = op_status;
        else if (addr == efs_pkg::DG_TYPE)
            next_rdata = ENC_TYPE;
        else if (addr < efs_pkg::DG_REVS)
            next_rdata = ST_RES[8'(31 - 8 * lane) -: 8];
        else
            next_rdata = (addr == efs_pkg::DG_REVS) ? REVS[15:8] : REVS[7:0];
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            rdata  <= 8'h00;
            rvalid <= 1'b0;
        end
        else
        begin
            rvalid <= rd;
            if (rd)
                rdata <= next_rdata;
        end
    end
endmodule

// *** efs_slave.sv ***
// encoder fieldbus slave data: configuration check, cyclic exchange, preset, diagnostics
// Overview of operation
// - velocity unit byte: 00 steps per second, 01 rpm, default 0, others refused
// - velocity unit only honoured in the position-velocity profile
// - config byte: bit7 consistency, bit6 word format, bits5:4 direction, bits3:0 length
// - D1h four input bytes, D3h eight input bytes, E1h four output bytes
// - position sent as 32-bit right-aligned word, most significant byte first
// - scaling enabled: position follows programmed total resolution, not hardware
// - position-velocity profile sends position then velocity, eight bytes
// - velocity word uses the currently selected unit
// - bit 31 clear leaves the preset untouched
// - bit 31 set: bits 0 to 30 are the preset value
// - preset value given to current shaft position, others offset from it
// - preset stored at once (here only on the third consecutive exchange of the same flagged word); master should preset only at standstill
// - diagnostic request answered at any time
// - sixteen diagnostic bytes: 0-5 standard, 6-15 encoder specific
// - extended diagnostic length sits in diagnostic byte 6
// - diagnostic byte order fixed, multi-byte fields most significant first
// - header byte reads 0Ah
// - alarms byte always 00h
// - operating status mirrors direction, extended profile, scaling, velocity exchange
//
// Design decisions made here: the address-and-strobe port and the register addresses.
module efs_slave #(
    parameter int          HW_BITS  = 30,
    parameter int          ST_BITS  = 16,
    parameter logic [15:0] IDENT    = 16'h0bee,  // arbitrary value
    parameter logic [7:0]  ENC_TYPE = 8'h01
) (
    input  wire logic                       mclk,
    input  wire logic                       reset,
    input  wire logic [efs_pkg::ADDR_W-1:0] addr,
    input  wire logic [31:0]                wdata,
    input  wire logic                       wr,
    input  wire logic                       rd,
    output logic      [31:0]                rdata,
    input  wire logic [HW_BITS-1:0]         phys_pos,
    input  wire logic [31:0]                vel_sps,
    input  wire logic [31:0]                vel_rpm,
    input  wire logic                       cfg_valid,
    input  wire logic [7:0]                 cfg_in_byte,
    input  wire logic [7:0]                 cfg_out_byte,
    output logic                            xchg_active,
    output logic                            cfg_fault,
    input  wire logic                       xchg_strobe,
    input  wire logic [31:0]                xchg_word,
    output logic                            in_valid,
    output logic                            in_len8,
    output logic      [31:0]                in_pos,
    output logic      [31:0]                in_vel,
    input  wire logic                       diag_rd,
    input  wire logic [3:0]                 diag_addr,
    input  wire logic [23:0]                station,
    input  wire logic [7:0]                 master_addr,
    output logic      [7:0]                 diag_byte,
    output logic                            diag_valid
);
    localparam logic [31:0] HW_TOTAL = 32'h1 << HW_BITS;
    localparam logic [31:0] HW_MAX   = HW_TOTAL - 32'h1;

    generate
        if (HW_BITS < 1 || HW_BITS > 31 || ST_BITS < 1 || ST_BITS > HW_BITS)
            $error("efs_slave: resolution parameters out of range");
    endgenerate

    efs_pkg::efs_state_e state;
    logic [7:0]  oper;
    logic [7:0]  vunit;
    logic [31:0] totres;
    logic [31:0] offset;
    logic [31:0] pdir;
    logic [31:0] scaled;
    logic [31:0] pos_cur;
    logic [31:0] res_eff;
    logic [63:0] prod;
    logic        pv;
    logic        scale_on;
    logic [7:0]  unit_eff;
    logic [7:0]  op_status;
    logic        cfg_match;
    logic        preset_hit;
    logic        xchg_take;
    logic [31:0] preset_val;
    logic [1:0]  set_run;

    // a + b folded once into [0, m); both inputs are below m
    function automatic logic [31:0] wrap_add(input logic [31:0] a, input logic [31:0] b,
                                             input logic [31:0] m);
        logic [32:0] s;
        s = {1'b0, a} + {1'b0, b};
        if (s >= {1'b0, m})
            s = s - {1'b0, m};
        return s[31:0];
    endfunction

    function automatic logic cfg_fields_ok(input logic [7:0] b, input logic [1:0] dir);
        return b[efs_pkg::CFG_CONS_BIT] && b[efs_pkg::CFG_WORD_BIT]
            && (b[efs_pkg::CFG_DIR_MSB:efs_pkg::CFG_DIR_LSB] == dir);
    endfunction

    assign pv       = oper[efs_pkg::OPER_EXT_BIT] && oper[efs_pkg::OPER_PV_BIT];
    assign scale_on = oper[efs_pkg::OPER_EXT_BIT] && oper[efs_pkg::OPER_SCALE_BIT];
    assign unit_eff = pv ? vunit : efs_pkg::VU_SPS;
    assign op_status = oper & efs_pkg::OPER_MASK;
    // a zero or oversized total resolution falls back to the hardware range
    assign res_eff  = (scale_on && totres != 32'h0 && totres <= HW_TOTAL) ? totres : HW_TOTAL;
    assign cfg_match = cfg_fields_ok(cfg_in_byte, efs_pkg::CFG_DIR_IN)
                    && cfg_fields_ok(cfg_out_byte, efs_pkg::CFG_DIR_OUT)
                    && (cfg_in_byte == (pv ? efs_pkg::CFG_IN8 : efs_pkg::CFG_IN4))
                    && (cfg_out_byte == efs_pkg::CFG_OUT4);
    assign xchg_take  = xchg_strobe && (state == efs_pkg::ST_XCHG);
    assign preset_val = {1'b0, xchg_word[30:0]};
    assign prod       = {32'h0, pdir} * {32'h0, res_eff};

    efs_preset_qual #(
        .HOLD (efs_pkg::PRESET_HOLD)
    ) u_qual (
        .mclk   (mclk),
        .reset  (reset),
        .enable (state == efs_pkg::ST_XCHG),
        .strobe (xchg_strobe),
        .word   (xchg_word),
        .hit    (preset_hit)
    );

    efs_diag_mem #(
        .IDENT    (IDENT),
        .ENC_TYPE (ENC_TYPE),
        .ST_BITS  (ST_BITS),
        .MT_BITS  (HW_BITS - ST_BITS)
    ) u_diag (
        .mclk        (mclk),
        .reset       (reset),
        .rd          (diag_rd),
        .addr        (diag_addr),
        .station     (station),
        .master_addr (master_addr),
        .op_status   (op_status),
        .rdata       (diag_byte),
        .rvalid      (diag_valid)
    );

    // register writes
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            oper   <= efs_pkg::OPER_RST;
            vunit  <= efs_pkg::VU_RST;
            totres <= HW_TOTAL;
        end
        else if (wr)
        begin
            if (addr == efs_pkg::REG_OPER)
                oper <= wdata[7:0] & efs_pkg::OPER_MASK;
            // only codes 0 and 1 taken
            if (addr == efs_pkg::REG_VUNIT && wdata[7:0] <= efs_pkg::VU_RPM)
                vunit <= wdata[7:0];
            if (addr == efs_pkg::REG_TOTRES)
                totres <= wdata;
        end
    end

    // register reads, unmapped reads return zero
    always_ff @(posedge mclk)
    begin
        if (reset)
            rdata <= 32'h0;
        else if (rd)
        begin
            unique case (addr)
                efs_pkg::REG_OPER:   rdata <= {24'h0, oper};
                efs_pkg::REG_VUNIT:  rdata <= {24'h0, vunit};
                efs_pkg::REG_TOTRES: rdata <= totres;
                efs_pkg::REG_STATUS: rdata <= {24'h0, unit_eff[0], pv, scale_on, 2'h0, state};
                efs_pkg::REG_POS:    rdata <= pos_cur;
                efs_pkg::REG_OFFSET: rdata <= offset;
                default:             rdata <= 32'h0;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            state <= efs_pkg::ST_WAIT_CFG;
        else if (cfg_valid)
            state <= cfg_match ? efs_pkg::ST_XCHG : efs_pkg::ST_FAULT;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            xchg_active <= 1'b0;
            cfg_fault   <= 1'b0;
        end
        else if (cfg_valid)
        begin
            xchg_active <= cfg_match;
            cfg_fault   <= !cfg_match;
        end
    end

    // position pipeline: direction, scaling, preset offset
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            pdir    <= 32'h0;
            scaled  <= 32'h0;
            pos_cur <= 32'h0;
        end
        else
        begin
            pdir    <= oper[efs_pkg::OPER_DIR_BIT] ? HW_MAX - 32'(phys_pos) : 32'(phys_pos);
            scaled  <= prod[HW_BITS +: 32];
            pos_cur <= wrap_add(scaled, offset, res_eff);
        end
    end

    // preset offset; preset assumed below res_eff
    // stored the same cycle
    always_ff @(posedge mclk)
    begin
        if (reset)
            offset <= 32'h0;
        else if (preset_hit)
            offset <= wrap_add(preset_val, res_eff - scaled, res_eff);
    end

    // hold check helper, independent of the qualifier's word compare
    always_ff @(posedge mclk)
    begin
        if (reset || state != efs_pkg::ST_XCHG)
            set_run <= 2'h0;
        else if (xchg_strobe && !xchg_word[efs_pkg::PRESET_BIT])
            set_run <= 2'h0;
        else if (xchg_strobe && set_run != 2'h3)
            set_run <= set_run + 2'h1;
    end

    // cyclic reply
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            in_valid <= 1'b0;
            in_len8  <= 1'b0;
            in_pos   <= 32'h0;
            in_vel   <= 32'h0;
        end
        else
        begin
            in_valid <= xchg_take;
            if (xchg_take)
            begin
                in_len8 <= pv;
                if (preset_hit)
                    in_pos <= preset_val;
                else
                    in_pos <= pos_cur;
                if (!pv)
                    in_vel <= 32'h0;
                else
                    in_vel <= (unit_eff == efs_pkg::VU_RPM) ? vel_rpm : vel_sps;
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    AST_VUNIT_RANGE: assert property (vunit <= efs_pkg::VU_RPM)
        else $error("velocity unit out of range");
    AST_UNIT_IGNORED: assert property (!pv |-> unit_eff == efs_pkg::VU_SPS)
        else $error("velocity unit honoured outside profile");
    AST_CFG_FAULT: assert property (cfg_valid && !cfg_match |=> cfg_fault && !xchg_active)
        else $error("bad configuration accepted");
    AST_NO_XCHG_UNCONF: assert property (in_valid |-> $past(state) == efs_pkg::ST_XCHG)
        else $error("reply without valid configuration");
    AST_CFG_CODE: assert property (cfg_valid && cfg_match |-> cfg_out_byte == efs_pkg::CFG_OUT4)
        else $error("wrong output code accepted");
    AST_POS_LATCH: assert property (xchg_take && !preset_hit |=> in_valid && in_pos == $past(pos_cur))
        else $error("position not sent");
    AST_POS_RANGE: assert property (##1 pos_cur < $past(res_eff))
        else $error("position outside resolution");
    AST_VEL_ZERO: assert property (in_valid && !in_len8 |-> in_vel == 32'h0)
        else $error("velocity sent outside profile");
    AST_VEL_UNIT: assert property (xchg_take && pv && unit_eff == efs_pkg::VU_RPM |=>
        in_vel == $past(vel_rpm))
        else $error("velocity unit wrong");
    AST_VEL_SPS: assert property (xchg_take && pv && !unit_eff[0] |=> in_vel == $past(vel_sps))
        else $error("velocity in steps per second wrong");
    AST_NO_PRESET: assert property (xchg_strobe && !xchg_word[31] |=> $stable(offset))
        else $error("preset moved without flag");
    AST_PRESET_ECHO: assert property (preset_hit |=> in_pos == $past(preset_val) ##2
        (pos_cur == $past(preset_val, 3) || $past(phys_pos, 3) != $past(phys_pos, 5)))
        else $error("preset not applied");
    AST_PRESET_HOLD: assert property (preset_hit |-> xchg_word[efs_pkg::PRESET_BIT] && set_run >= 2'h2)
        else $error("preset without hold");
    AST_DIAG_ANS: assert property (diag_rd |=> diag_valid)
        else $error("diagnostic request unanswered");
    AST_DIAG_HDR: assert property (diag_rd && diag_addr == efs_pkg::DG_HEADER |=>
        diag_byte == efs_pkg::DIAG_HDR)
        else $error("diagnostic header wrong");
    AST_DIAG_ALARM: assert property (diag_rd && diag_addr == efs_pkg::DG_ALARMS |=> diag_byte == 8'h00)
        else $error("alarms byte not zero");
    AST_DIAG_ID: assert property (diag_rd && diag_addr == efs_pkg::DG_ID_MSB |=>
        diag_byte == IDENT[15:8])
        else $error("identifier byte out of order");
    AST_DIAG_OPSTAT: assert property (diag_rd && diag_addr == efs_pkg::DG_OPSTAT |=>
        diag_byte[6:4] == 3'h0 && !diag_byte[2] && diag_byte[7] == $past(oper[efs_pkg::OPER_PV_BIT]))
        else $error("operating status byte wrong");
    AST_CFG_FIELDS: assert property (cfg_valid && !cfg_in_byte[efs_pkg::CFG_CONS_BIT] |=> cfg_fault)
        else $error("configuration without consistency bit accepted");
    AST_CFG_PROFILE: assert property (cfg_valid && pv && cfg_in_byte == efs_pkg::CFG_IN4 |=> cfg_fault)
        else $error("short input code accepted in velocity profile");
    AST_CFG_OK: assert property (cfg_valid && cfg_match |=> xchg_active && !cfg_fault)
        else $error("matching configuration refused");
    AST_FLAGS_EXCL: assert property (!(xchg_active && cfg_fault))
        else $error("exchange and fault flags both set");
    AST_LEN8: assert property (in_valid |-> in_len8 == $past(pv))
        else $error("reply length does not follow profile");

    COV_PRESET: cover property (preset_hit);
    COV_PV_XCHG: cover property (xchg_take && pv ##1 in_valid);
    COV_CFG_BAD: cover property (cfg_valid && !cfg_match);
    COV_DIAG: cover property (diag_rd && diag_addr == efs_pkg::DG_OPSTAT);
    COV_RECOVER: cover property (cfg_fault ##1 xchg_active);
endmodule

// *** efs_master_model.sv ***
// fieldbus master model: configuration bytes and cyclic exchange words
module efs_master_model
(
    input  wire logic        mclk,
    output logic             cfg_valid,
    output logic [7:0]       cfg_in_byte,
    output logic [7:0]       cfg_out_byte,
    output logic             xchg_strobe,
    output logic [31:0]      xchg_word
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        cfg_valid = 1'b0;
        cfg_in_byte = 8'h00;
        cfg_out_byte = 8'h00;
        xchg_strobe = 1'b0;
        xchg_word = 32'h0000_0000;
    end

    task automatic configure(input logic [7:0] in_b, input logic [7:0] out_b);
        @(posedge mclk);
        cfg_valid <= 1'b1;
        cfg_in_byte <= in_b;
        cfg_out_byte <= out_b;
        @(posedge mclk);
        cfg_valid <= 1'b0;
        // released bytes must not keep looking valid
        cfg_in_byte <= ~in_b;
        cfg_out_byte <= ~out_b;
        #1;
    endtask

    // caller repeats the word to hold a preset
    task automatic exchange(input logic [31:0] word);
        @(posedge mclk);
        xchg_strobe <= 1'b1;
        xchg_word <= word;
        @(posedge mclk);
        xchg_strobe <= 1'b0;
        xchg_word <= ~word;
        #1;
    endtask
endmodule

// *** efs_slave_bench.sv ***
// self-checking bench of the encoder fieldbus slave data block
module efs_slave_bench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [15:0] IDENT_T = 16'h5a3c;  // arbitrary value
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] rdata;
    logic [29:0] phys_pos = 30'h0005_5000;
    logic [31:0] vel_sps = 32'h0000_1234;
    logic [31:0] vel_rpm = 32'h0000_0056;
    logic        cfg_valid, xchg_active, cfg_fault, xchg_strobe, in_valid, in_len8, diag_rd = 1'b0, diag_valid;
    logic [7:0]  cfg_in_byte, cfg_out_byte, diag_byte;
    logic [31:0] xchg_word, in_pos, in_vel;
    logic [3:0]  diag_addr = 4'h0;
    logic [23:0] station = 24'h12_3456;
    logic [7:0]  master_addr = 8'h02;
    int          miscompares = 0;
    int          comparisons = 0;
    int          cycles = 0;

    efs_slave #(.IDENT(IDENT_T)) dut_u (.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .phys_pos(phys_pos), .vel_sps(vel_sps), .vel_rpm(vel_rpm),
        .cfg_valid(cfg_valid), .cfg_in_byte(cfg_in_byte), .cfg_out_byte(cfg_out_byte),
        .xchg_active(xchg_active), .cfg_fault(cfg_fault), .xchg_strobe(xchg_strobe), .xchg_word(xchg_word),
        .in_valid(in_valid), .in_len8(in_len8), .in_pos(in_pos), .in_vel(in_vel), .diag_rd(diag_rd),
        .diag_addr(diag_addr), .station(station), .master_addr(master_addr), .diag_byte(diag_byte),
        .diag_valid(diag_valid));
    efs_master_model mst_u (.mclk(mclk), .cfg_valid(cfg_valid), .cfg_in_byte(cfg_in_byte),
        .cfg_out_byte(cfg_out_byte), .xchg_strobe(xchg_strobe), .xchg_word(xchg_word));

    always #2 mclk = ~mclk;

    task automatic stop_test();
        $display("miscompares %0d comparisons %0d", miscompares, comparisons);
        if (miscompares == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // a hang is cut short well past the expected run
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            stop_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask

    task automatic t_regs();
        rd_reg(efs_pkg::REG_OPER, 32'h0000_000a);
        rd_reg(efs_pkg::REG_VUNIT, 32'h0);
        rd_reg(8'hfc, 32'h0);
        // scaled to a 2^20 range: position drops ten bits
        wr_reg(efs_pkg::REG_TOTRES, 32'h0010_0000);
        repeat (5) @(posedge mclk);
        rd_reg(efs_pkg::REG_POS, 32'h0000_0154);
        wr_reg(efs_pkg::REG_TOTRES, 32'h4000_0000);
        repeat (5) @(posedge mclk);
    endtask

    task automatic t_preset();
        mst_u.exchange(32'h0);
        chk({31'h0, in_valid}, 32'h0);
        mst_u.configure(8'h51, 8'he1);
        chk({30'h0, xchg_active, cfg_fault}, 32'h1);
        mst_u.configure(8'hd1, 8'he1);
        chk({30'h0, xchg_active, cfg_fault}, 32'h2);
        mst_u.exchange(32'h0);
        chk({in_valid, in_len8, in_pos[29:0]}, 32'h8005_5000);
        repeat (2) mst_u.exchange(32'h8000_1000);
        chk(in_pos, 32'h0005_5000);
        mst_u.exchange(32'h8000_1000);
        chk(in_pos, 32'h0000_1000);
        @(posedge mclk);
        phys_pos <= 30'h0005_5005;
        repeat (4) @(posedge mclk);
        mst_u.exchange(32'h0);
        chk(in_pos, 32'h0000_1005);
    endtask

    task automatic t_pos_vel();
        wr_reg(efs_pkg::REG_VUNIT, 32'h1);
        rd_reg(efs_pkg::REG_STATUS, 32'h0000_0022);
        wr_reg(efs_pkg::REG_OPER, 32'h0000_008a);
        vel_rpm <= 32'h0000_0abc;
        rd_reg(efs_pkg::REG_STATUS, 32'h0000_00e2);
        wr_reg(efs_pkg::REG_VUNIT, 32'h2);
        rd_reg(efs_pkg::REG_VUNIT, 32'h1);
        mst_u.configure(8'hd1, 8'he1);
        chk({30'h0, xchg_active, cfg_fault}, 32'h1);
        mst_u.configure(8'hd3, 8'he1);
        chk({30'h0, xchg_active, cfg_fault}, 32'h2);
        mst_u.exchange(32'h0);
        chk({31'h0, in_len8}, 32'h1);
        chk(in_pos, 32'h0000_1005);
        chk(in_vel, 32'h0000_0abc);
        wr_reg(efs_pkg::REG_VUNIT, 32'h0);
        vel_sps <= 32'h0000_4321;
        mst_u.exchange(32'h0);
        chk(in_vel, 32'h0000_4321);
    endtask

    task automatic t_diag();
        logic [127:0] exp;
        @(posedge mclk);
        station <= 24'ha5_0c3f;
        master_addr <= 8'h7e;
        exp = {24'ha5_0c3f, 8'h7e, IDENT_T, 8'h0a, 8'h00, 8'h8a, 8'h01, 32'h0001_0000, 16'h4000};
        for (int i = 0; i < 16; i++)
        begin
            @(posedge mclk);
            diag_addr <= 4'(i);
            diag_rd <= 1'b1;
            @(posedge mclk);
            diag_rd <= 1'b0;
            #1 chk({23'h0, diag_valid, diag_byte}, {24'h1, exp[127 - 8 * i -: 8]});
        end
    endtask

    initial
    begin
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        t_regs();
        t_preset();
        t_pos_vel();
        t_diag();
        stop_test();
    end
endmodule
